// ==== flash_cmd_pkg.sv ====
// package: opcodes, status layout, protection bounds and state types
`default_nettype none
package flash_cmd_pkg;

	// ==========================================================
	// opcodes
	localparam logic [7:0] cmd_legacy_ident = 8'hab;
	localparam logic [7:0] cmd_std_ident = 8'h9f;
	localparam logic [7:0] cmd_maker_device_ident = 8'h90;
	localparam logic [7:0] cmd_write_enable = 8'h06;
	localparam logic [7:0] cmd_write_disable = 8'h04;
	localparam logic [7:0] cmd_status_read = 8'h05;
	localparam logic [7:0] cmd_status_write = 8'h01;
	localparam logic [7:0] cmd_normal_read = 8'h03;
	localparam logic [7:0] cmd_fast_read = 8'h0b;
	localparam logic [7:0] cmd_dual_out_read = 8'h3b;
	localparam logic [7:0] cmd_page_write = 8'h02;
	localparam logic [7:0] cmd_sector_wipe = 8'hd7;
	localparam logic [7:0] cmd_sector_wipe_alt = 8'h20;
	localparam logic [7:0] cmd_block_wipe = 8'hd8;
	localparam logic [7:0] cmd_full_wipe = 8'hc7;
	localparam logic [7:0] cmd_full_wipe_alt = 8'h60;

	// ==========================================================
	// status layout and sequence lengths
	localparam int prot_lo = 2;
	localparam int prot_hi = 4;
	localparam int lock_pos = 7;
	localparam int msb_pos = 7;
	localparam logic [7:0] status_reset = 8'h00;
	localparam logic [2:0] no_protect = 3'h0;
	localparam logic [2:0] count_zero = 3'h0;
	localparam logic [2:0] last_bit = 3'h7;
	localparam logic [2:0] len_one = 3'h1;
	localparam logic [2:0] len_status_write = 3'h2;
	localparam logic [2:0] len_header = 3'h4;
	localparam logic [2:0] len_page_write = 3'h5;
	localparam logic [2:0] len_max = 3'h7;

	// ==========================================================
	// protected regions of the array
	localparam logic [23:0] quarter_base = 24'h01_8000;
	localparam logic [23:0] half_base = 24'h01_0000;
	localparam logic [23:0] array_mask = 24'h01_ffff;

	// ==========================================================
	// internal write cycle timing
	localparam int clk_period_ns = 4;
	localparam int write_time_ns = 1000;
	localparam int busy_cycles_int =
		(write_time_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [11:0] busy_cycles = 12'(busy_cycles_int);
	localparam logic [11:0] busy_last = 12'h001;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		kind_none,
		kind_status_write,
		kind_page_write,
		kind_sector_wipe,
		kind_block_wipe,
		kind_full_wipe
	} op_kind_t;

	typedef struct packed {
		logic valid;
		op_kind_t kind;
		logic [23:0] addr;
		logic [7:0] data;
	} exec_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} pins_t;

	// pin levels while the link is idle: deselected, clock low, no pause
	localparam pins_t pins_idle = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
		hold_n: 1'b1, wp_n: 1'b1};

	typedef struct packed {
		logic cs_prev;
		logic sck_prev;
		logic held;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] data;
		logic ignore;
		logic [7:0] out_sr;
		logic so;
		logic so_oe;
		logic write_latch;
		logic [2:0] bp;
		logic lock;
		logic busy;
		logic [11:0] busy_cnt;
		exec_t exec;
	} state_t;

endpackage : flash_cmd_pkg
`default_nettype wire

// ==== flash_pin_sync.sv ====
// two-stage synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
module flash_pin_sync
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// asynchronous pins and their synchronised copy
	input wire flash_cmd_pkg::pins_t d,
	output var flash_cmd_pkg::pins_t q
);
	import flash_cmd_pkg::*;

	// ==========================================================
	// stages
	typedef struct packed {
		pins_t first;
		pins_t second;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// first stage feeds only the second
	always_comb
	begin
		next_st.first = d;
		next_st.second = st.first;
	end

	// idle levels: deselected, hold released, clock low
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			st <= '{first: pins_idle, second: pins_idle};
		else
			st <= next_st;
	end

	assign q = st.second;

endmodule : flash_pin_sync
`default_nettype wire

// ==== flash_cmd_front.sv ====
// serial flash command front end with status and write protection
//
// Functional notes
// R1 - status bit 0 is read-only busy, high during internal write cycles
// R2 - status bit 1 is the write latch, zero after reset
// R3 - bits 2-4 are writable protect bits; bits 5-6 read zero
// R4 - bit 7 is writable status lock, zero after reset
// R5 - low protect bits select none, upper quarter, half, all; inhibit writes
// R6 - program, erase, status write execute only on whole bytes
// R7 - status locked only when lock bit set and write protect low
// R8 - program, erase, status write ignored while write latch clear
// R9 - sample input on rising clock while selected, msb first, 8-bit opcode
// R10 - master sends opcode first and deselects after last bit
// R11 - decode legacy, standard and maker/device ident opcodes
// R12 - decode normal, fast and dual-output read opcodes
// R13 - decode page program, sector, block and chip erase opcodes
// R14 - decode write enable, write disable, status read and status write
// R15 - hold low with clock low pauses; sequence state kept
// R16 - while paused ignore input and clock, output floats
// R17 - write latch clears at write cycle end and on write disable
// R18 - chip erase only when all protect bits are zero
// R19 - while busy only status read is accepted
// R20 - unknown opcode ignored until deselect, no state change
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_front
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial pins from the master
	input wire logic cs_n,
	input wire logic sck,
	input wire logic serial_io_in,
	input wire logic hold_n,
	input wire logic wp_n,
	// serial data output pin
	output var logic so,
	output var logic so_oe,
	// status and array requests
	output var logic [7:0] status_flags,
	output var flash_cmd_pkg::exec_t exec
);
	import flash_cmd_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [7:0] status_of(input state_t s);
		status_of = {s.lock, 2'b00, s.bp, s.write_latch, s.busy}; // R1 R2 R3 R4
	endfunction : status_of

	function automatic logic is_known(input logic [7:0] op);
		case (op) // R11 R12 R13 R14
			cmd_legacy_ident, cmd_std_ident, cmd_maker_device_ident,
			cmd_write_enable, cmd_write_disable, cmd_status_read,
			cmd_status_write, cmd_normal_read, cmd_fast_read,
			cmd_dual_out_read, cmd_page_write, cmd_sector_wipe,
			cmd_sector_wipe_alt, cmd_block_wipe, cmd_full_wipe,
			cmd_full_wipe_alt:
				is_known = 1'b1;
			default:
				is_known = 1'b0;
		endcase
	endfunction : is_known

	function automatic logic is_protected(input logic [2:0] bp,
		input logic [23:0] addr);
		logic [23:0] a;
		a = addr & array_mask;
		case (bp[1:0]) // R5
			2'b00: is_protected = 1'b0;
			2'b01: is_protected = (a >= quarter_base);
			2'b10: is_protected = (a >= half_base);
			default: is_protected = 1'b1;
		endcase
	endfunction : is_protected

	// ==========================================================
	// pin synchronisation
	pins_t pin;

	flash_pin_sync u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({cs_n, sck, serial_io_in, hold_n, wp_n}),
		.q(pin)
	);

	// ==========================================================
	// state
	state_t st;
	state_t next_st;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic locked;

	// edges of the synchronised pins
	assign cs_rise = pin.cs_n && !st.cs_prev;
	assign sck_rise = pin.sck && !st.sck_prev;
	assign sck_fall = !pin.sck && st.sck_prev;
	assign locked = st.lock && !pin.wp_n; // R7

	// next state of the whole front end
	always_comb
	begin
		logic [7:0] b;
		logic whole;
		logic wr_ok;
		logic start;
		op_kind_t kind;
		b = 8'h00;
		whole = (st.bit_cnt == count_zero); // R6
		wr_ok = whole && !st.ignore && st.write_latch && !st.busy; // R8 R19
		start = 1'b0;
		kind = kind_none;
		next_st = st;
		next_st.exec.valid = 1'b0;
		next_st.cs_prev = pin.cs_n;
		next_st.sck_prev = pin.sck;
		// internal write cycle countdown
		if (st.busy)
		begin
			next_st.busy_cnt = st.busy_cnt - busy_last;
			if (st.busy_cnt == busy_last)
			begin
				next_st.busy = 1'b0; // R1
				next_st.write_latch = 1'b0; // R17
			end
		end
		if (pin.cs_n)
		begin
			// deselect ends the sequence and executes writes
			if (cs_rise && st.byte_cnt != count_zero)
			begin
				case (st.opcode)
					cmd_write_enable:
						if (whole && !st.ignore)
							next_st.write_latch = 1'b1; // R2
					cmd_write_disable:
						if (whole && !st.ignore)
							next_st.write_latch = 1'b0; // R17
					cmd_status_write:
						if (wr_ok && st.byte_cnt >= len_status_write &&
							!locked) // R7
						begin
							next_st.bp = st.data[prot_hi:prot_lo]; // R3
							next_st.lock = st.data[lock_pos]; // R4
							start = 1'b1;
							kind = kind_status_write;
						end
					cmd_page_write:
						if (wr_ok && st.byte_cnt >= len_page_write &&
							!is_protected(st.bp, st.addr)) // R5
						begin
							start = 1'b1;
							kind = kind_page_write;
						end
					cmd_sector_wipe, cmd_sector_wipe_alt:
						if (wr_ok && st.byte_cnt >= len_header &&
							!is_protected(st.bp, st.addr)) // R5
						begin
							start = 1'b1;
							kind = kind_sector_wipe;
						end
					cmd_block_wipe:
						if (wr_ok && st.byte_cnt >= len_header &&
							!is_protected(st.bp, st.addr)) // R5
						begin
							start = 1'b1;
							kind = kind_block_wipe;
						end
					cmd_full_wipe, cmd_full_wipe_alt:
						if (wr_ok && st.bp == no_protect) // R18
						begin
							start = 1'b1;
							kind = kind_full_wipe;
						end
					default:
						;
				endcase
			end
			next_st.bit_cnt = count_zero;
			next_st.byte_cnt = count_zero;
			next_st.ignore = 1'b0; // R20
			next_st.held = 1'b0;
			next_st.so_oe = 1'b0;
		end
		else
		begin
			// pause enters and leaves only while the clock is low
			if (!pin.sck)
				next_st.held = !pin.hold_n; // R15
			if (!st.held && sck_rise)
			begin
				b = {st.shift[6:0], pin.si}; // R9
				next_st.shift = b;
				next_st.bit_cnt = st.bit_cnt + 3'h1;
				if (st.bit_cnt == last_bit)
				begin
					if (st.byte_cnt != len_max)
						next_st.byte_cnt = st.byte_cnt + 3'h1;
					if (st.byte_cnt == count_zero)
					begin
						next_st.opcode = b; // R9
						if (!is_known(b)) // R20
							next_st.ignore = 1'b1;
						if (st.busy && b != cmd_status_read) // R19
							next_st.ignore = 1'b1;
					end
					else if (st.byte_cnt < len_header)
						next_st.addr = {st.addr[15:0], b};
					if (st.byte_cnt == len_header ||
						(st.byte_cnt == len_one &&
						st.opcode == cmd_status_write))
						next_st.data = b;
					next_st.out_sr = status_of(st);
				end
			end
			// status bytes leave msb first on falling clock edges
			if (!st.held && sck_fall && !st.ignore &&
				st.opcode == cmd_status_read && st.byte_cnt != count_zero)
			begin
				next_st.so = st.out_sr[msb_pos];
				next_st.out_sr = {st.out_sr[6:0], st.out_sr[msb_pos]};
				next_st.so_oe = 1'b1;
			end
			if (next_st.held)
				next_st.so_oe = 1'b0; // R16
		end
		// launch the internal write cycle
		if (start)
		begin
			next_st.busy = 1'b1; // R1
			next_st.busy_cnt = busy_cycles;
			next_st.exec.valid = 1'b1;
			next_st.exec.kind = kind;
			next_st.exec.addr = st.addr & array_mask;
			next_st.exec.data = st.data;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.cs_prev <= 1'b1;
			st.lock <= status_reset[lock_pos];
			st.bp <= status_reset[prot_hi:prot_lo];
		end
		else
			st <= next_st;
	end

	// outputs straight from state
	assign so = st.so;
	assign so_oe = st.so_oe;
	assign status_flags = status_of(st);
	assign exec = st.exec;

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_reserved_bits_zero: assert property (status_flags[6:5] == 2'b00) // R3
		else $error("reserved status bits not zero");
	a_write_needs_latch: assert property ($rose(st.busy) |-> $past(st.write_latch)) // R8
		else $error("write cycle began without write latch");
	a_latch_cleared_end: assert property ($fell(st.busy) |-> !st.write_latch) // R17
		else $error("write latch survived end of write cycle");
	a_busy_min_length: assert property ($rose(st.busy) |-> st.busy[*8]) // R1
		else $error("busy flag dropped too early");
	a_exec_when_idle: assert property
		(exec.valid |-> st.busy && !$past(st.busy)) // R19
		else $error("request issued while already busy");
	a_whole_bytes_only: assert property
		(exec.valid |-> $past(st.bit_cnt) == 3'h0) // R6
		else $error("request after partial byte");
	a_chip_wipe_clean: assert property
		(exec.valid && exec.kind == kind_full_wipe |-> st.bp == 3'h0) // R18
		else $error("chip erase with protection set");
	a_lock_holds_bits: assert property
		(cs_rise && locked |=> $stable(st.bp) && $stable(st.lock)) // R7
		else $error("locked status register changed");
	a_pause_floats_out: assert property (st.held |-> !so_oe) // R16
		else $error("output driven while paused");
	a_protect_region: assert property
		(exec.valid && exec.kind == kind_page_write |->
		!is_protected(st.bp, exec.addr)) // R5
		else $error("program into protected region");

	c_page_write: cover property (exec.valid && exec.kind == kind_page_write);
	c_status_out: cover property ($rose(so_oe) ##[1:64] st.busy);
	c_pause_resume: cover property (st.held ##1 !st.held);
	c_locked_write: cover property
		(cs_rise && locked && st.opcode == cmd_status_write);

endmodule : flash_cmd_front
`default_nettype wire

// ==== spi_master_model.sv ====
// serial master model that frames commands for the flash front end
`timescale 1ns/10ps
`default_nettype none
module spi_master_model
(
	// serial pins toward the device
	output var logic cs_n,
	output var logic sck,
	output var logic si,
	output var logic hold_n,
	// serial data back from the device
	input wire logic so,
	input wire logic so_oe
);
	logic oe_in_hold;
	// ==========================================================
	// idle: deselected, clock parked low between frames
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		oe_in_hold = 1'b0;
	end
	// ==========================================================
	// one frame, msb first, with a pause before bit p
	task automatic xfer(input logic [63:0] d, input int n, input int p,
		output logic [63:0] rx);
		rx = '0;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++)
		begin
			si = d[63 - i];
			if (i == p)
			begin
				hold_n = 1'b0;
				si = ~d[63 - i];
				#62.5 sck = 1'b1;
				#62.5 sck = 1'b0;
				#20 oe_in_hold = so_oe;
				si = d[63 - i];
				hold_n = 1'b1;
				#40;
			end
			#62.5 sck = 1'b1;
			rx = {rx[62:0], so_oe ? so : ~so}; // floating line reads inverted
			#62.5 sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		si = ~si; // released line no longer shows the last bit
		#100;
	endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// ==== tb_flash_cmd_front.sv ====
// self-checking bench for the flash command front end
`timescale 1ns/10ps
`default_nettype none
module tb_flash_cmd_front;
	import flash_cmd_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic wp_n = 1'b1;
	logic cs_n, sck, si, hold_n, so, so_oe, exp_ok;
	logic [7:0] status_flags, op, e;
	logic [23:0] a;
	exec_t exec, last_ex;
	logic [63:0] rx;
	logic [31:0] seed = 32'h0000_b99c;
	int miscompares = 0;
	int cmp_count = 0;
	int n_exec = 0;
	int n0;
	logic [7:0] ops[6] = '{cmd_page_write, cmd_sector_wipe,
		cmd_sector_wipe_alt, cmd_block_wipe, cmd_full_wipe, cmd_full_wipe_alt};
	op_kind_t kinds[6] = '{kind_page_write, kind_sector_wipe,
		kind_sector_wipe, kind_block_wipe, kind_full_wipe, kind_full_wipe};
	int lens[6] = '{40, 32, 32, 32, 8, 8};
	logic [23:0] bnd[3] = '{24'h01_8000, 24'h01_7fff, 24'h00_ffff};
	// ==========================================================
	// clock, device, master and request counter
	always #2 sys_clk = ~sys_clk;
	flash_cmd_front dut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
		.sck(sck), .serial_io_in(si), .hold_n(hold_n), .wp_n(wp_n),
		.so(so), .so_oe(so_oe), .status_flags(status_flags), .exec(exec));
	spi_master_model master (.cs_n(cs_n), .sck(sck), .si(si),
		.hold_n(hold_n), .so(so), .so_oe(so_oe));
	always @(posedge sys_clk)
		if (exec.valid === 1'b1)
		begin
			n_exec <= n_exec + 1;
			last_ex <= exec;
		end
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic prot(input logic [1:0] bp, input logic [23:0] x);
		return (bp == 2'h3) || (bp == 2'h2 && x[16:0] >= 17'h1_0000) ||
			(bp == 2'h1 && x[16:0] >= 17'h1_8000);
	endfunction : prot
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic send(input logic [63:0] d, input int n, input int p = 99);
		master.xfer(d, n, p, rx);
	endtask : send
	task automatic wait_idle();
		for (int i = 0; status_flags[0] !== 1'b0; i++)
		begin
			if (i == 400)
			begin
				miscompares++;
				conclude();
			end
			@(posedge sys_clk);
		end
	endtask : wait_idle
	task automatic wsr(input logic [7:0] v, input logic ok);
		n0 = n_exec;
		send({cmd_write_enable, 56'h0}, 8);
		send({cmd_status_write, v, 48'h0}, 16);
		check(n_exec - n0, ok);
		wait_idle();
	endtask : wsr
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(status_flags, status_reset);
		check(so_oe, 1'b0);
		n0 = n_exec;
		send({cmd_status_write, 8'h1c, 48'h0}, 16);
		check(n_exec - n0, 0);
		send({cmd_write_enable, 56'h0}, 8);
		check(status_flags[1], 1'b1);
		send({cmd_write_disable, 56'h0}, 8);
		check(status_flags[1], 1'b0);
		$display("test reset and latch done");
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			e = seed[7:0] & 8'h9c;
			send({cmd_write_enable, 56'h0}, 8);
			n0 = n_exec;
			send({cmd_status_write, seed[7:0], 48'h0}, 15);
			check(n_exec - n0, 0);
			send({cmd_status_write, seed[7:0], 48'h0}, 16);
			check(n_exec - n0, 1);
			check(last_ex.kind, kind_status_write);
			check(last_ex.data, seed[7:0]);
			check(status_flags[1:0], 2'h3);
			wait_idle();
			check(status_flags, e);
			send({cmd_status_read, 56'h0}, 24, 20);
			check({rx[15:4], rx[2:0]}, {e, e[7:4], e[2:0]});
			check(master.oe_in_hold, 1'b0);
		end
		$display("test status write and read done");
		wsr(8'h80, 1'b1);
		check(status_flags, 8'h80);
		@(posedge sys_clk);
		wp_n <= 1'b0;
		wsr(8'h04, 1'b0);
		send({cmd_write_disable, 56'h0}, 8);
		check(status_flags, 8'h80);
		@(posedge sys_clk);
		wp_n <= 1'b1;
		wsr(8'h00, 1'b1);
		$display("test lock done");
		for (int b = 0; b < 4; b++)
		begin
			wsr({3'h0, 3'(b), 2'h0}, 1'b1);
			for (int k = 0; k < 6; k++)
			begin
				seed = lfsr(seed);
				op = ops[k];
				a = k < 3 ? bnd[k] : {7'h0, seed[16:0]};
				exp_ok = k > 3 ? b == 0 : !prot(2'(b), a);
				n0 = n_exec;
				send({cmd_write_enable, 56'h0}, 8);
				send({op, a, seed[31:24], 24'h0}, lens[k]);
				check(n_exec - n0, exp_ok);
				if (exp_ok && k < 4)
					check({last_ex.kind, last_ex.addr}, {kinds[k], a});
				if (exp_ok && k == 0)
					check(last_ex.data, seed[31:24]);
				if (exp_ok && k > 3)
					check(last_ex.kind, kinds[k]);
				wait_idle();
			end
		end
		$display("test protection done");
		send({cmd_write_disable, 56'h0}, 8);
		send({8'h5a, cmd_write_enable, 48'h0}, 16);
		check(status_flags[1], 1'b0);
		$display("test unknown opcode done");
		conclude();
	end
endmodule : tb_flash_cmd_front
`default_nettype wire
